// >>> core/ulm_pkg.sv
// constants and types shared by the line, modem and status block
package ulm_pkg;
   // register byte offsets on the axi4-lite slave
   localparam logic [7:0] ADDR_DATA        = 8'h00;
   localparam logic [7:0] ADDR_DIV_HIGH    = 8'h04;
   localparam logic [7:0] ADDR_ENHANCED    = 8'h08;
   localparam logic [7:0] ADDR_LINE_FORMAT = 8'h0C;
   localparam logic [7:0] ADDR_MODEM_OUT   = 8'h10;
   localparam logic [7:0] ADDR_LINE_STATUS = 8'h14;
   // line_format_control fields
   localparam int LF_STOP     = 2;
   localparam int LF_PAR_EN   = 3;
   localparam int LF_EVEN     = 4;
   localparam int LF_FORCE    = 5;
   localparam int LF_BREAK    = 6;
   localparam int LF_DIV_SEL  = 7;
   // modem_output_control fields
   localparam int MC_TERM     = 0;
   localparam int MC_RTS      = 1;
   localparam int MC_RX_POL   = 2;
   localparam int MC_USER_TWO = 3;
   localparam int MC_LOOP     = 4;
   localparam int MC_XON_ANY  = 5;
   localparam int MC_IR       = 6;
   localparam int MC_PRESC    = 7;
   // enhanced_feature_control field
   localparam int EF_ENABLE   = 4;
   // reset values
   localparam logic [7:0]  LF_RESET  = 8'h00;
   localparam logic [7:0]  MC_RESET  = 8'h00;
   localparam logic [7:0]  EF_RESET  = 8'h00;
   localparam logic [15:0] DIV_RESET = 16'h0001;
   // timing counts, in oversampling ticks; PRESC_LAST in enabled clock cycles
   localparam logic [7:0]  STOP_ONE      = 8'h10;
   localparam logic [7:0]  STOP_ONE_HALF = 8'h18;
   localparam logic [7:0]  STOP_TWO      = 8'h20;
   localparam logic [3:0]  HALF_BIT      = 4'h7;
   localparam logic [3:0]  LAST_TICK     = 4'hF;
   localparam logic [3:0]  IR_PULSE      = 4'h3;
   localparam logic [1:0]  PRESC_LAST    = 2'h3;
   // axi responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // receiver states, gray along idle-start-bits-wait
   typedef enum logic [1:0] {
      RX_IDLE  = 2'h0,
      RX_START = 2'h1,
      RX_BITS  = 2'h3,
      RX_WAIT  = 2'h2
   } ulm_rx_e;
endpackage : ulm_pkg

// >>> core/ulm_line_modem_ctrl.sv
// line format, modem control and line status of one serial channel
//
// Contract
// - two format bits pick 5..8 data bits
// - stop bit: one, or 1.5/2 when set
// - parity enable adds and checks parity
// - even-select clear odd, set even
// - forced parity: high if even clear
// - break bit holds transmit line low
// - divisor bit steers data to divisor latch
// - terminal-ready bit drives its pin low
// - request bit drives pin low, auto overrides
// - infrared receive polarity picks idle level
// - loopback: polarity bit shows as ring
// - user output two drives multifunction pin
// - loopback bit selects local loopback
// - resume-on-any restarts transmitter per character
// - infrared mode routes line, idles low
// - prescaler divides baud clock by four
// - enhanced bits need enhanced enable set
// - data ready while character held
// - overrun when holding full, drop character
// - parity/framing flags describe held character
// - break on full low frame, once
// - holding empty on handoff, clear on write
// - error flags raise line status interrupt
// - line status read clears that interrupt
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module ulm_line_modem_ctrl
   import ulm_pkg::*;
(
   // clock, reset, enable
   input  wire logic        i_clock,
   input  wire logic        i_rstn,
   input  wire logic        i_clock_en,
   // axi4-lite write channels
   input  wire logic        i_awvalid,
   output      logic        o_awready,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_wvalid,
   output      logic        o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   output      logic        o_bvalid,
   input  wire logic        i_bready,
   output      logic [1:0]  o_bresp,
   // axi4-lite read channels
   input  wire logic        i_arvalid,
   output      logic        o_arready,
   input  wire logic [7:0]  i_araddr,
   output      logic        o_rvalid,
   input  wire logic        i_rready,
   output      logic [31:0] o_rdata,
   output      logic [1:0]  o_rresp,
   // serial line
   input  wire logic        i_rx,
   output      logic        o_tx,
   // modem pins
   output      logic        o_terminal_ready_n,
   output      logic        o_request_to_send_n,
   output      logic        o_multifunction_pin_n,
   input  wire logic        i_ring_indicator_n,
   output      logic        o_ring_status,
   // links to neighbouring blocks
   input  wire logic        i_auto_rts_enable,
   input  wire logic        i_auto_rts_n,
   input  wire logic        i_mf_select_user,
   input  wire logic        i_sw_flow_enable,
   input  wire logic [7:0]  i_xon_char,
   input  wire logic [7:0]  i_xoff_char,
   output      logic        o_tx_resume,
   output      logic        o_line_status_irq
);

   // whole block state, registered in one place
   typedef struct packed {
      logic [7:0]  line_format;   // format, break, divisor select
      logic [7:0]  modem_output;  // modem and mode bits
      logic [7:0]  enhanced;      // enhanced enable
      logic [15:0] divisor;       // baud divisor latch
      logic [1:0]  pre_cnt;       // divide-by-four prescaler
      logic [15:0] div_cnt;       // baud divider
      logic [7:0]  transmit_holding;           // transmit holding
      logic        thr_full;      // holding has a byte
      logic        tx_busy;       // shifter active
      logic [11:0] tx_frame;      // start, data, parity, stops
      logic [7:0]  tx_ticks;      // ticks into the frame
      logic [7:0]  tx_total;      // frame length in ticks
      ulm_rx_e     rx_state;      // receiver state
      logic [3:0]  rx_sub;        // tick within a bit
      logic [3:0]  rx_idx;        // bit being sampled
      logic [9:0]  rx_bits;       // sampled bits
      logic [7:0]  receive_holding;           // receive holding
      logic        rx_ready;      // character held
      logic        perr;          // parity tag
      logic        ferr;          // framing tag
      logic        brk;           // break tag
      logic        overrun;       // sticky overrun
      logic        awready;       // write address and data ready
      logic        bvalid;        // write response valid
      logic [1:0]  bresp;         // write response code
      logic        arready;       // read address ready
      logic        rvalid;        // read data valid
      logic [31:0] rdata;         // read data
      logic [1:0]  rresp;         // read response code
      logic        tx;            // serial out
      logic        term_n;        // terminal ready pin
      logic        rts_n;         // request to send pin
      logic        mf_n;          // multifunction pin
      logic        ring;          // ring status
      logic        resume;        // one-cycle resume pulse
      logic        irq;           // line status pending
   } ulm_state_s;

   ulm_state_s r;       // current state
   ulm_state_s next_r;  // next state

   // decoded helpers, all set in the combinational process
   logic       enh, loop, ir, presc, pre_ok, tick, dsel, par_en;
   logic       tx_bit, line_in, wr_go, rd_go, lsr_read;
   logic       rx_done, rx_break, rx_perr, rx_ferr, err_event;
   logic [3:0] nbits, last;
   logic [7:0] mask, rx_data, lsr_val, stop_ticks;
   logic [11:0] frame;

   // parity bit for a character under the current format
   function automatic logic par_bit(input logic [7:0] d,
                                    input logic [7:0] m,
                                    input logic [7:0] lf);
      logic x;
      x = ^(d & m);
      if (lf[LF_FORCE])
         par_bit = !lf[LF_EVEN];
      else
         par_bit = lf[LF_EVEN] ? x : !x;
   endfunction : par_bit

   // all next-state logic
   always_comb begin
      next_r    = r;
      next_r.resume = 1'b0;
      lsr_read  = 1'b0;
      rx_done   = 1'b0;
      rx_break  = 1'b0;
      rx_perr   = 1'b0;
      rx_ferr   = 1'b0;
      err_event = 1'b0;
      rx_data   = 8'h00;
      // infrared, prescaler and resume-any bits only live with enhanced enable set
      enh   = r.enhanced[EF_ENABLE];
      loop  = r.modem_output[MC_LOOP];
      ir    = enh && r.modem_output[MC_IR];
      presc = enh && r.modem_output[MC_PRESC];
      dsel  = r.line_format[LF_DIV_SEL];
      par_en = r.line_format[LF_PAR_EN];
      nbits = 4'h5 + {2'h0, r.line_format[1:0]};
      mask  = 8'hFF >> (2'h3 - r.line_format[1:0]);
      last  = nbits + {3'h0, par_en};
      // stop length depends on the data length
      if (!r.line_format[LF_STOP])
         stop_ticks = STOP_ONE;
      else if (r.line_format[1:0] == 2'h0)
         stop_ticks = STOP_ONE_HALF;
      else
         stop_ticks = STOP_TWO;
      // baud tick, prescaled by four when asked
      pre_ok = !presc || (r.pre_cnt == PRESC_LAST);
      tick   = i_clock_en && pre_ok &&
               (r.div_cnt == r.divisor - 16'h0001);
      next_r.pre_cnt = r.pre_cnt + 2'h1;
      if (pre_ok) begin
         next_r.div_cnt = tick ? 16'h0000 : r.div_cnt + 16'h0001;
      end
      // frame image: start low, data, parity, stops high
      frame = 12'hFFF;
      frame[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i < int'(nbits))
            frame[i + 1] = r.transmit_holding[i];
      end
      if (par_en)
         frame[nbits + 4'h1] = par_bit(r.transmit_holding, mask, r.line_format);
      // transmitter: take holding byte, then walk the frame
      tx_bit = r.tx_busy ? r.tx_frame[r.tx_ticks[7:4]] : 1'b1;
      if (!r.tx_busy && r.thr_full) begin
         next_r.tx_busy  = 1'b1;
         next_r.tx_frame = frame;
         next_r.tx_ticks = 8'h00;
         next_r.tx_total = {last + 4'h1, 4'h0} + stop_ticks;
         next_r.thr_full = 1'b0;
      end else if (r.tx_busy && tick) begin
         if (r.tx_ticks == r.tx_total - 8'h01)
            next_r.tx_busy = 1'b0;
         else
            next_r.tx_ticks = r.tx_ticks + 8'h01;
      end
      // serial out: break beats everything
      if (r.line_format[LF_BREAK])
         next_r.tx = 1'b0;
      else if (loop)
         next_r.tx = !ir;
      else if (ir)
         next_r.tx = r.tx_busy && !tx_bit &&
                     (r.tx_ticks[3:0] < IR_PULSE);
      else
         next_r.tx = tx_bit;
      // modem output pins parked inactive in loopback; ring status takes the polarity bit
      next_r.term_n = loop || !r.modem_output[MC_TERM];
      if (loop)
         next_r.rts_n = 1'b1;
      else if (i_auto_rts_enable)
         next_r.rts_n = i_auto_rts_n;
      else
         next_r.rts_n = !r.modem_output[MC_RTS];
      next_r.mf_n = loop || !i_mf_select_user ||
                    !r.modem_output[MC_USER_TWO];
      next_r.ring = loop ? r.modem_output[MC_RX_POL]
                         : !i_ring_indicator_n;
      // line status image
      lsr_val = {r.perr || r.ferr || r.brk,
                 !r.thr_full && !r.tx_busy, !r.thr_full,
                 r.brk, r.ferr, r.perr, r.overrun, r.rx_ready};
      // write path: address and data taken together
      next_r.awready = !r.awready && !r.bvalid &&
                       i_awvalid && i_wvalid;
      wr_go = r.awready && i_awvalid && i_wvalid;
      if (r.bvalid && i_bready)
         next_r.bvalid = 1'b0;
      if (wr_go) begin
         next_r.bvalid = 1'b1;
         next_r.bresp  = RESP_OKAY;
         case (i_awaddr)
            ADDR_DATA: begin
               if (!i_wstrb[0]) begin
                  // no low lane, nothing stored
               end else if (dsel) begin
                  next_r.divisor[7:0] = i_wdata[7:0];
               end else begin
                  next_r.transmit_holding      = i_wdata[7:0];
                  next_r.thr_full = 1'b1;
               end
            end
            ADDR_DIV_HIGH: begin
               if (!dsel)
                  next_r.bresp = RESP_SLVERR;
               else if (i_wstrb[0])
                  next_r.divisor[15:8] = i_wdata[7:0];
            end
            ADDR_ENHANCED: begin
               if (i_wstrb[0])
                  next_r.enhanced = i_wdata[7:0];
            end
            ADDR_LINE_FORMAT: begin
               if (i_wstrb[0])
                  next_r.line_format = i_wdata[7:0];
            end
            ADDR_MODEM_OUT: begin
               if (i_wstrb[0])
                  next_r.modem_output = i_wdata[7:0];
            end
            ADDR_LINE_STATUS: begin
               // read only, write ignored
            end
            default: next_r.bresp = RESP_SLVERR;
         endcase
      end
      // read path, one cycle after arready
      next_r.arready = !r.arready && !r.rvalid && i_arvalid;
      rd_go = r.arready && i_arvalid;
      if (r.rvalid && i_rready)
         next_r.rvalid = 1'b0;
      if (rd_go) begin
         next_r.rvalid = 1'b1;
         next_r.rresp  = RESP_OKAY;
         next_r.rdata  = 32'h0000_0000;
         case (i_araddr)
            ADDR_DATA: begin
               if (dsel) begin
                  next_r.rdata[7:0] = r.divisor[7:0];
               end else begin
                  next_r.rdata[7:0] = r.receive_holding;
                  next_r.rx_ready   = 1'b0;
                  next_r.perr       = 1'b0;
                  next_r.ferr       = 1'b0;
                  next_r.brk        = 1'b0;
               end
            end
            ADDR_DIV_HIGH: begin
               if (dsel)
                  next_r.rdata[7:0] = r.divisor[15:8];
               else
                  next_r.rresp = RESP_SLVERR;
            end
            ADDR_ENHANCED:    next_r.rdata[7:0] = r.enhanced;
            ADDR_LINE_FORMAT: next_r.rdata[7:0] = r.line_format;
            ADDR_MODEM_OUT:   next_r.rdata[7:0] = r.modem_output;
            ADDR_LINE_STATUS: begin
               next_r.rdata[7:0] = lsr_val;
               lsr_read       = 1'b1;
               next_r.overrun = 1'b0;
               next_r.irq     = 1'b0;
            end
            default: next_r.rresp = RESP_SLVERR;
         endcase
      end
      // receive line: loopback, infrared or pin
      if (loop)
         line_in = tx_bit;
      else if (ir)
         line_in = r.modem_output[MC_RX_POL] ? i_rx : !i_rx;
      else
         line_in = i_rx;
      // receiver, sampled mid-bit on the tick
      case (r.rx_state)
         RX_IDLE: begin
            if (tick && !line_in) begin
               next_r.rx_state = RX_START;
               next_r.rx_sub   = 4'h0;
            end
         end
         RX_START: begin
            if (tick && r.rx_sub == HALF_BIT) begin
               // a glitch shorter than half a bit is ignored
               next_r.rx_state = line_in ? RX_IDLE : RX_BITS;
               next_r.rx_sub   = 4'h0;
               next_r.rx_idx   = 4'h0;
               next_r.rx_bits  = 10'h000;
            end else if (tick) begin
               next_r.rx_sub = r.rx_sub + 4'h1;
            end
         end
         RX_BITS: begin
            if (tick) begin
               next_r.rx_sub = r.rx_sub + 4'h1;
               if (r.rx_sub == LAST_TICK) begin
                  next_r.rx_bits[r.rx_idx] = line_in;
                  next_r.rx_idx = r.rx_idx + 4'h1;
                  rx_done = (r.rx_idx == last);
               end
            end
         end
         RX_WAIT: begin
            if (line_in)
               next_r.rx_state = RX_IDLE;
         end
         default: next_r.rx_state = RX_IDLE;
      endcase
      // character complete: classify and store
      if (rx_done) begin
         rx_data  = next_r.rx_bits[7:0] & mask;
         rx_break = (next_r.rx_bits == 10'h000);
         rx_perr  = par_en && (next_r.rx_bits[nbits] !=
                    par_bit(rx_data, mask, r.line_format));
         rx_ferr  = !next_r.rx_bits[last];
         // after a break wait for mark so only one is stored
         next_r.rx_state = rx_break ? RX_WAIT : RX_IDLE;
         next_r.resume   = enh && r.modem_output[MC_XON_ANY];
         if (next_r.rx_ready) begin
            next_r.overrun = 1'b1;
            err_event      = 1'b1;
         end else if (!(i_sw_flow_enable &&
                        (rx_data == i_xon_char ||
                         rx_data == i_xoff_char))) begin
            next_r.receive_holding      = rx_data;
            next_r.rx_ready = 1'b1;
            next_r.perr     = rx_perr;
            next_r.ferr     = rx_ferr;
            next_r.brk      = rx_break;
            err_event       = rx_perr || rx_ferr || rx_break;
         end
      end
      // a new error beats a clearing read
      if (err_event)
         next_r.irq = 1'b1;
   end

   // state register, frozen while the enable is low
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         r              <= '0;
         r.line_format  <= LF_RESET;
         r.modem_output <= MC_RESET;
         r.enhanced     <= EF_RESET;
         r.divisor      <= DIV_RESET;
         r.tx           <= 1'b1;
         r.term_n       <= 1'b1;
         r.rts_n        <= 1'b1;
         r.mf_n         <= 1'b1;
      end else if (i_clock_en) begin
         r <= next_r;
      end
   end

   // outputs straight from the state register
   assign o_awready             = r.awready;
   assign o_wready              = r.awready;
   assign o_bvalid              = r.bvalid;
   assign o_bresp               = r.bresp;
   assign o_arready             = r.arready;
   assign o_rvalid              = r.rvalid;
   assign o_rdata               = r.rdata;
   assign o_rresp               = r.rresp;
   assign o_tx                  = r.tx;
   assign o_terminal_ready_n    = r.term_n;
   assign o_request_to_send_n   = r.rts_n;
   assign o_multifunction_pin_n = r.mf_n;
   assign o_ring_status         = r.ring;
   assign o_tx_resume           = r.resume;
   assign o_line_status_irq     = r.irq;

   // checks on the registered behaviour
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rstn);

   chk_break_line_low: assert property (
      i_clock_en && r.line_format[LF_BREAK] |=> !o_tx)
      else $error("break set but line not low");
   chk_term_ready_pin: assert property (
      i_clock_en && !loop |=>
         o_terminal_ready_n == !$past(r.modem_output[MC_TERM]))
      else $error("terminal ready pin wrong");
   chk_rts_pin_drive: assert property (
      i_clock_en && !loop && !i_auto_rts_enable |=>
         o_request_to_send_n == !$past(r.modem_output[MC_RTS]))
      else $error("request pin wrong");
   chk_loop_ring_status: assert property (
      i_clock_en && loop |=>
         o_ring_status == $past(r.modem_output[MC_RX_POL]))
      else $error("loopback ring status wrong");
   chk_ir_idle_low: assert property (
      i_clock_en && ir && !loop && !r.tx_busy &&
      !r.line_format[LF_BREAK] |=> !o_tx)
      else $error("infrared line not idle low");
   chk_presc_tick_gap: assert property (
      tick && presc |=> (!tick || !presc) [*3])
      else $error("prescaled tick too soon");
   chk_thr_write_full: assert property (
      i_clock_en && wr_go && i_wstrb[0] && !dsel &&
      i_awaddr == ADDR_DATA |=> r.thr_full && !lsr_val[5])
      else $error("holding write did not clear empty");
   chk_overrun_sets: assert property (
      i_clock_en && rx_done && r.rx_ready && !rd_go |=>
         r.overrun && $stable(r.receive_holding))
      else $error("overrun not flagged");
   chk_error_irq_set: assert property (
      i_clock_en && err_event |=> o_line_status_irq)
      else $error("error did not raise interrupt");
   chk_lsr_read_clear: assert property (
      i_clock_en && lsr_read && !err_event |=> !o_line_status_irq)
      else $error("status read did not clear interrupt");

endmodule : ulm_line_modem_ctrl

// >>> sim/ulm_remote_peer.sv
// remote serial device: frame sender and frame catcher
`timescale 1ns/1ps
module ulm_remote_peer #(
   parameter int BIT_CLOCKS = 16  // divisor 1, prescaler off
) (
   // clock and line
   input  wire logic        i_clock,
   input  wire logic        i_line,
   output      logic        o_line,
   // last eleven bits after a start bit
   output      logic [10:0] o_frame
);
   // send start bit, then eleven bits lsb first, then mark
   task automatic send(input logic [10:0] f);
      o_line <= 1'b0;
      repeat (BIT_CLOCKS) @(posedge i_clock);
      for (int i = 0; i < 11; i++) begin
         o_line <= f[i];
         repeat (BIT_CLOCKS) @(posedge i_clock);
      end
      o_line <= 1'b1;
      // one mark clock so back-to-back frames never drive twice at once
      @(posedge i_clock);
   endtask : send
   // catcher samples mid-bit; line idles at mark between frames
   initial begin
      o_line = 1'b1;
      o_frame = '1;
      forever begin
         @(negedge i_line);
         repeat (BIT_CLOCKS / 2) @(posedge i_clock);
         for (int i = 0; i < 11; i++) begin
            repeat (BIT_CLOCKS) @(posedge i_clock);
            o_frame[i] = i_line;
         end
      end
   end
endmodule : ulm_remote_peer

// >>> sim/tb_top.sv
// self-checking bench for the line, modem and status block
`timescale 1ns/1ps
module tb_top;
   import ulm_pkg::*;
   logic        clk, rstn, awv, wv, brdy, arv, rrdy, mfs, aen, an, ce, rin;
   logic        seen;
   logic [7:0]  aa, ara, v;
   logic [31:0] wd;
   logic [3:0]  ws;
   logic [1:0]  r;
   logic [10:0] x;
   wire logic   awr, wrr, bv, arr, rv, tx, rx, trn, rtn, mfn, ring, irq;
   wire logic   res;
   wire logic [1:0]  br, rr;
   wire logic [31:0] rdt;
   wire logic [10:0] frame;
   int          fails, checked, cyc;
   logic [7:0]  fmts [5] = '{8'h00, 8'h0B, 8'h1B, 8'h2B, 8'h3B};
   ulm_line_modem_ctrl uut (.i_clock(clk), .i_rstn(rstn), .i_clock_en(ce),
      .i_awvalid(awv), .o_awready(awr), .i_awaddr(aa), .i_wvalid(wv),
      .o_wready(wrr), .i_wdata(wd), .i_wstrb(ws), .o_bvalid(bv),
      .i_bready(brdy), .o_bresp(br), .i_arvalid(arv), .o_arready(arr),
      .i_araddr(ara), .o_rvalid(rv), .i_rready(rrdy), .o_rdata(rdt),
      .o_rresp(rr), .i_rx(rx), .o_tx(tx), .o_terminal_ready_n(trn),
      .o_request_to_send_n(rtn), .o_multifunction_pin_n(mfn),
      .i_ring_indicator_n(rin), .o_ring_status(ring),
      .i_auto_rts_enable(aen), .i_auto_rts_n(an), .i_mf_select_user(mfs),
      .i_sw_flow_enable(1'b0), .i_xon_char(8'h11), .i_xoff_char(8'h13),
      .o_tx_resume(res), .o_line_status_irq(irq));
   // remember any resume pulse for the resume-on-any check
   always @(posedge clk) begin
      if (res) seen <= 1'b1;
   end
   ulm_remote_peer peer (.i_clock(clk), .i_line(tx), .o_line(rx),
      .o_frame(frame));
   // expected frame bits after the start bit, idle mark beyond the end
   function automatic logic [10:0] frm(input logic [7:0] f, d);
      int n;
      n = 5 + int'(f[1:0]);
      frm = 11'h7FF;
      for (int i = 0; i < n; i++) frm[i] = d[i];
      if (f[3]) frm[n] = f[5] ? ~f[4] : (^(d & ~(8'hFF << n))) ^ ~f[4];
   endfunction : frm
   task automatic chk(input string n, input logic [10:0] s, e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // write: both channels offered together, held until taken
   task automatic wr(input logic [7:0] a, d, output logic [1:0] q);
      @(posedge clk);
      awv <= 1'b1;
      wv <= 1'b1;
      aa <= a;
      wd <= {24'h00_0000, d};
      do @(posedge clk); while (!awr);
      awv <= 1'b0;
      wv <= 1'b0;
      brdy <= 1'b1;
      do @(posedge clk); while (!bv);
      q = br;
      brdy <= 1'b0;
      // one more edge so registered pins already show the write
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic [1:0] q);
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      rrdy <= 1'b1;
      do @(posedge clk); while (!rv);
      d = rdt[7:0];
      q = rr;
      rrdy <= 1'b0;
   endtask : rd
   task automatic st(input logic [7:0] e);
      rd(ADDR_LINE_STATUS, v, r);
      chk("status", v, e);
   endtask : st
   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // hang guard, far above the few thousand cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         final_report;
      end
   end
   initial begin
      {rstn, awv, wv, brdy, arv, rrdy, mfs, aen, an, seen} = '0;
      {aa, ara, wd} = '0;
      ws = 4'hF;
      {ce, rin} = 2'h3;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      rd(ADDR_LINE_FORMAT, v, r);
      chk("format", v, LF_RESET);
      st(8'h60);
      chk("pins", {trn, rtn, mfn, tx}, 11'h00F);
      rd(8'h1C, v, r);
      chk("unmapped", r, RESP_SLVERR);
      wr(ADDR_DIV_HIGH, 8'h00, r);
      chk("div shut", r, RESP_SLVERR);
      wr(ADDR_LINE_FORMAT, 8'h80, r);
      rd(ADDR_DATA, v, r);
      chk("div low", v, DIV_RESET[7:0]);
      wr(ADDR_DIV_HIGH, 8'h00, r);
      chk("div open", r, RESP_OKAY);
      wr(ADDR_LINE_STATUS, 8'hFF, r);
      st(8'h60);
      wr(ADDR_LINE_FORMAT, 8'h40, r);
      chk("break", tx, 1'b0);
      wr(ADDR_LINE_FORMAT, 8'h00, r);
      chk("mark", tx, 1'b1);
      repeat (200) @(posedge clk);
      // enable low: ring status must not follow its pin
      ce <= 1'b0;
      rin <= 1'b0;
      repeat (3) @(posedge clk);
      chk("frozen", ring, 1'b0);
      ce <= 1'b1;
      mfs <= 1'b1;
      wr(ADDR_MODEM_OUT, 8'h0B, r);
      chk("pins on", {trn, rtn, mfn, ring}, 11'h001);
      aen <= 1'b1;
      an <= 1'b1;
      repeat (3) @(posedge clk);
      chk("auto", rtn, 1'b1);
      rin <= 1'b1;
      wr(ADDR_MODEM_OUT, 8'h14, r);
      chk("loop", {trn, rtn, mfn, ring}, 11'h00F);
      wr(ADDR_MODEM_OUT, 8'h00, r);
      // transmit each format in the table: 5-bit plain, 8-bit with each parity mode
      foreach (fmts[i]) begin
         wr(ADDR_LINE_FORMAT, fmts[i], r);
         wr(ADDR_DATA, 8'hA5, r);
         st(8'h20);
         repeat (230) @(posedge clk);
         chk("sent", frame, frm(fmts[i], 8'hA5));
         st(8'h60);
      end
      // infrared bit ignored until enabled; then infrared and prescaler
      wr(ADDR_MODEM_OUT, 8'h44, r);
      chk("no ir", tx, 1'b1);
      wr(ADDR_ENHANCED, 8'h10, r);
      chk("ir idle", tx, 1'b0);
      wr(ADDR_MODEM_OUT, 8'hC4, r);
      wr(ADDR_DATA, 8'hA5, r);
      repeat (230) @(posedge clk);
      st(8'h20);
      repeat (600) @(posedge clk);
      st(8'h60);
      wr(ADDR_MODEM_OUT, 8'h20, r);
      wr(ADDR_LINE_FORMAT, 8'h1B, r);
      // receive: good, bad parity, bad stop, overrun, break
      x = frm(8'h1B, 8'h5A);
      peer.send(x);
      st(8'h61);
      chk("resume", seen, 1'b1);
      rd(ADDR_DATA, v, r);
      chk("data", v, 8'h5A);
      x[8] = ~x[8];
      peer.send(x);
      chk("irq", irq, 1'b1);
      st(8'hE5);
      chk("irq off", irq, 1'b0);
      rd(ADDR_DATA, v, r);
      x = frm(8'h1B, 8'h5A);
      x[9] = 1'b0;
      peer.send(x);
      st(8'hE9);
      rd(ADDR_DATA, v, r);
      peer.send(frm(8'h1B, 8'h11));
      peer.send(frm(8'h1B, 8'h22));
      st(8'h63);
      rd(ADDR_DATA, v, r);
      chk("kept", v, 8'h11);
      peer.send(11'h000);
      rd(ADDR_LINE_STATUS, v, r);
      chk("rx break", v & 8'h11, 8'h11);
      final_report;
   end
endmodule : tb_top
